// ---- logic/qdl_map.svh ----
/*
 Constants of the quad converter code-load core: register offsets,
 field positions, reset values and timing counts.
 Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef QDL_MAP_SVH
`define QDL_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define QDL_OFS_CMD 8'h00
`define QDL_OFS_STAT 8'h04
`define QDL_OFS_LDCFG 8'h08
`define QDL_OFS_REF 8'h0C
`define QDL_OFS_CODE0 8'h10
`define QDL_OFS_ACT0 8'h20

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define QDL_CMD_VAL_LSB 0
`define QDL_CMD_SEL_LSB 16
`define QDL_CMD_OP_LSB 24

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define QDL_NCH 4
`define QDL_CODE_W 12
`define QDL_REF_RST 2'h0
`define QDL_LDCFG_RST 4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define QDL_CLK_MHZ 100
`define QDL_CAL_US 200
`define QDL_CAL_CYC (`QDL_CAL_US * `QDL_CLK_MHZ)

`endif

// ---- logic/qdl_pkg.sv ----
/*
 Types of the quad converter code-load core.
 Assumes the constants of qdl_map.svh.
*/
package qdl_pkg;

   typedef enum logic [3:0]
   {
      QDL_OP_NOP = 4'h0,
      QDL_OP_CODE = 4'h1,
      QDL_OP_LOAD = 4'h2,
      QDL_OP_CODE_LOAD = 4'h3,
      QDL_OP_SOFT_ZERO = 4'h4,
      QDL_OP_SOFT_RESTART = 4'h5
   } qdl_op_t;

   typedef enum logic [1:0]
   {
      QDL_REF_EXT = 2'h0,
      QDL_REF_2V048 = 2'h1,
      QDL_REF_2V500 = 2'h2,
      QDL_REF_4V096 = 2'h3
   } qdl_ref_t;

   typedef enum
   {
      QDL_ST_CAL,
      QDL_ST_RUN
   } qdl_state_t;

endpackage : qdl_pkg

// ---- logic/qdl_core.sv ----
/*
 Digital control core of a four-channel voltage-output converter: pending
 and active code registers, commands, load pin, clear pin and reference.
 Assumes software on AXI4-Lite stands in for the serial front end; the
 load and clear pins arrive asynchronously from the board.
*/
// Overview of operation
// - Four channels; resolution of 8, 10 or 12 bits by parameter.
// - Each channel has pending and active registers; active sets output.
// - Commands route values to control registers, one or many channels.
// - Pending-only and write-and-update commands both store the pending code.
// - Write-and-update also writes the active register directly.
// - Transfer command or load pin copies pending into active registers.
// - Registers keep their contents while channels are powered down.
// - Commands during power-down still update registers normally.
// - Soft clear and soft reset zero all pending and active registers.
// - Software selects internal reference 2.048, 2.500 or 4.096 V.
// - After reset the reference selection is external.
// - Reset initialises every channel output to code zero.
// - Active-low clear input zeroes the device without any clock.
// - Falling load pin updates the enabled channels together.
// - While load pin stays low, active registers are transparent.
// - A configuration register enables the load pin per channel.
// - After reset a 200 us calibration ignores every command.
// - Clear low zeroes all pending and active registers and aborts a command in progress.
`timescale 1ns/1ns
`include "qdl_map.svh"

module qdl_core
#(
   parameter int RES = 12,
   parameter int CAL_CYC = `QDL_CAL_CYC
)
(
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic HW_OUTPUT_UPDATE_N,
   input wire logic ASYNC_ZERO_N,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [47:0] ACTIVE_CODES,
   output logic [1:0] REF_SEL
);

   localparam int W = `QDL_CODE_W;
   localparam int N = `QDL_NCH;
   localparam logic [W-1:0] RES_MASK = W'({W{1'b1}} << (W - RES));

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic ld_meta_r;
   logic ld_sync_r;
   logic ld_prev_r;
   logic clr_meta_r;
   logic clr_sync_r;

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         ld_meta_r <= 1'b1;
         ld_sync_r <= 1'b1;
         ld_prev_r <= 1'b1;
      end
      else
      begin
         ld_meta_r <= HW_OUTPUT_UPDATE_N;
         ld_sync_r <= ld_meta_r;
         ld_prev_r <= ld_sync_r;
      end
   end

   // The clear pin is an asynchronous preset of its synchroniser, so the
   // zeroing starts with no clock; release is still taken through two stages.
   // asynchronous clear entry
   always_ff @(posedge SYS_CLK or negedge ASYNC_ZERO_N)
   begin
      if (!ASYNC_ZERO_N)
      begin
         clr_meta_r <= 1'b1;
         clr_sync_r <= 1'b1;
      end
      else
      begin
         clr_meta_r <= 1'b0;
         clr_sync_r <= clr_meta_r;
      end
   end

   logic clr_act;
   assign clr_act = clr_sync_r;

   // ----------------------------------------------------------------------
   // Calibration sequencer
   // ----------------------------------------------------------------------
   qdl_pkg::qdl_state_t st_r;
   logic [31:0] cal_cnt_r;

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         st_r <= qdl_pkg::QDL_ST_CAL;
         cal_cnt_r <= 32'h0;
      end
      else
      begin
         case (st_r)
            qdl_pkg::QDL_ST_CAL:
            begin
               if (cal_cnt_r == 32'(CAL_CYC - 1))
               begin
                  st_r <= qdl_pkg::QDL_ST_RUN;
               end
               cal_cnt_r <= cal_cnt_r + 32'h1;
            end
            qdl_pkg::QDL_ST_RUN:
            begin
               cal_cnt_r <= cal_cnt_r;
            end
            default:
            begin
               st_r <= qdl_pkg::QDL_ST_CAL;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   logic aw_have_r;
   logic w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_fire;

   assign S_AXI_AWREADY = !aw_have_r && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_have_r && !S_AXI_BVALID;
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign wr_fire = aw_have_r && w_have_r;

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h0;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= 2'h0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_have_r <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
         end
         if (wr_fire)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= map_ok(aw_addr_r) ? 2'h0 : 2'h2;
         end
         else if (S_AXI_BVALID && S_AXI_BREADY)
         begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   function automatic logic map_ok(input logic [7:0] a);
      map_ok = (a[1:0] == 2'h0) && (a < 8'h30);
   endfunction : map_ok

   // Command fields; a write with no lane 3 strobe carries no command.
   logic wr_cmd;
   logic wr_ldcfg;
   logic wr_ref;
   qdl_pkg::qdl_op_t op;
   logic [N-1:0] sel;
   logic [W-1:0] val;
   logic accept;

   assign accept = wr_fire && st_r == qdl_pkg::QDL_ST_RUN && !clr_act;
   assign wr_cmd = accept && aw_addr_r == `QDL_OFS_CMD && w_strb_r[3];
   assign wr_ldcfg = accept && aw_addr_r == `QDL_OFS_LDCFG && w_strb_r[0];
   assign wr_ref = accept && aw_addr_r == `QDL_OFS_REF && w_strb_r[0];
   assign op = qdl_pkg::qdl_op_t'(w_data_r[`QDL_CMD_OP_LSB +: 4]);
   assign sel = w_data_r[`QDL_CMD_SEL_LSB +: N];
   assign val = w_data_r[`QDL_CMD_VAL_LSB +: W] & RES_MASK;

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   logic [N-1:0] ld_en_r;
   logic [1:0] ref_r;

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         ld_en_r <= `QDL_LDCFG_RST;
         ref_r <= `QDL_REF_RST;
      end
      else
      begin
         if (wr_ldcfg)
         begin
            ld_en_r <= w_data_r[N-1:0];
         end
         if (wr_ref)
         begin
            ref_r <= w_data_r[1:0];
         end
         else if (wr_cmd && op == qdl_pkg::QDL_OP_SOFT_RESTART)
         begin
            ref_r <= `QDL_REF_RST;
         end
      end
   end

   assign REF_SEL = ref_r;

   // ----------------------------------------------------------------------
   // Channel registers
   // ----------------------------------------------------------------------
   logic [W-1:0] code_r [N];
   logic [W-1:0] act_r [N];
   logic ld_fall;
   logic ld_low;
   logic soft_zero;

   assign ld_fall = ld_prev_r && !ld_sync_r;
   assign ld_low = !ld_sync_r;
   assign soft_zero = wr_cmd && (op == qdl_pkg::QDL_OP_SOFT_ZERO
      || op == qdl_pkg::QDL_OP_SOFT_RESTART);

   // Power-down is outside this core, so nothing here ever disturbs the
   // registers on it: contents are kept and commands act as usual.
   // retention in power-down
   always_ff @(posedge SYS_CLK or negedge ASYNC_ZERO_N)
   begin
      if (!ASYNC_ZERO_N)
      begin
         for (int i = 0; i < N; i++)
         begin
            code_r[i] <= '0;
            act_r[i] <= '0;
         end
      end
      else if (SRST || clr_sync_r || soft_zero)
      begin
         for (int i = 0; i < N; i++)
         begin
            code_r[i] <= '0;
            act_r[i] <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            if (wr_cmd && sel[i] && (op == qdl_pkg::QDL_OP_CODE
               || op == qdl_pkg::QDL_OP_CODE_LOAD))
            begin
               code_r[i] <= val;
            end
            if (wr_cmd && sel[i] && op == qdl_pkg::QDL_OP_CODE_LOAD)
            begin
               act_r[i] <= val;
            end
            else if (wr_cmd && sel[i] && op == qdl_pkg::QDL_OP_LOAD)
            begin
               act_r[i] <= code_r[i];
            end
            else if (ld_en_r[i] && (ld_fall || ld_low))
            begin
               act_r[i] <= code_r[i];
            end
         end
      end
   end

   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         ACTIVE_CODES[i*W +: W] = act_r[i];
      end
   end

   // ----------------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------------
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      logic [3:0] ix;
      ix = a[5:2];
      rd_mux = 32'h0;
      if (a == `QDL_OFS_STAT)
      begin
         rd_mux = {29'h0, clr_act, st_r == qdl_pkg::QDL_ST_RUN, !ld_sync_r};
      end
      else if (a == `QDL_OFS_LDCFG)
      begin
         rd_mux = {28'h0, ld_en_r};
      end
      else if (a == `QDL_OFS_REF)
      begin
         rd_mux = {30'h0, ref_r};
      end
      else if (a >= `QDL_OFS_CODE0 && a < `QDL_OFS_ACT0)
      begin
         rd_mux = {20'h0, code_r[ix[1:0]]};
      end
      else if (a >= `QDL_OFS_ACT0 && a < 8'h30)
      begin
         rd_mux = {20'h0, act_r[ix[1:0]]};
      end
   endfunction : rd_mux

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= 2'h0;
      end
      else if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_mux(S_AXI_ARADDR);
         S_AXI_RRESP <= map_ok(S_AXI_ARADDR) ? 2'h0 : 2'h2;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_ld_fall;
      ld_prev_r && !ld_sync_r;
   endsequence

   AST_SOFT_ZERO: assert property (@(posedge SYS_CLK) disable iff (SRST)
      soft_zero |=> act_r[0] == '0 && code_r[3] == '0)
      else $error("Soft zero left a register nonzero.");

   AST_CAL_IGNORE: assert property (@(posedge SYS_CLK) disable iff (SRST)
      st_r == qdl_pkg::QDL_ST_CAL |=> code_r[0] == '0 && act_r[1] == '0
      && REF_SEL == `QDL_REF_RST)
      else $error("Command took effect during calibration.");

   AST_CODE_LOAD: assert property (@(posedge SYS_CLK) disable iff (SRST)
      wr_cmd && sel[1] && op == qdl_pkg::QDL_OP_CODE_LOAD && !soft_zero
      && ASYNC_ZERO_N |=> act_r[1] == $past(val) || !ASYNC_ZERO_N)
      else $error("Write-and-update missed the active register.");

   AST_CODE_ONLY: assert property (@(posedge SYS_CLK) disable iff (SRST)
      wr_cmd && sel[2] && op == qdl_pkg::QDL_OP_CODE && ASYNC_ZERO_N
      |=> code_r[2] == $past(val) || !ASYNC_ZERO_N)
      else $error("Pending write missed.");

   AST_LD_PIN: assert property (@(posedge SYS_CLK) disable iff (SRST)
      s_ld_fall and ld_en_r[0] and !wr_cmd and !clr_act
      |=> act_r[0] == $past(code_r[0]) || !ASYNC_ZERO_N)
      else $error("Load pin did not update channel.");

   AST_LD_DIS: assert property (@(posedge SYS_CLK) disable iff (SRST)
      !ld_en_r[3] && !wr_cmd && !clr_act && ASYNC_ZERO_N
      |=> $stable(act_r[3]) || !ASYNC_ZERO_N)
      else $error("Disabled channel followed load pin.");

   AST_CLR_HOLD: assert property (@(posedge SYS_CLK) disable iff (SRST)
      clr_sync_r |=> act_r[2] == '0 && code_r[0] == '0)
      else $error("Registers nonzero while clear held.");

   AST_RES_MASK: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (code_r[1] & ~RES_MASK) == '0)
      else $error("Unused low bits set.");

   AST_REF_RST: assert property (@(posedge SYS_CLK)
      SRST |=> REF_SEL == `QDL_REF_RST)
      else $error("Reference not external after reset.");

endmodule : qdl_core

// ---- test/qdl_host_model.sv ----
/*
 Host model that issues register bus transfers to the code-load core.
 Assumes one clock and that the bench calls its tasks one at a time.
*/
`timescale 1ns/1ns
module qdl_host_model
(
   input wire logic clk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // -------------------------------------------------------------------
   // Bus transfers
   // -------------------------------------------------------------------
   initial
   begin
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hF;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // Handshakes are sampled at the falling edge: inputs hold still until
   // the next rising edge, so this equals what that edge sees.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw_hit;
      logic w_hit;
      logic b_hit;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_hit = 1'b0;
      while (!b_hit)
      begin
         @(negedge clk);
         aw_hit = awvalid && awready;
         w_hit = wvalid && wready;
         b_hit = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw_hit)
            awvalid <= 1'b0;
         if (w_hit)
            wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic ar_hit;
      logic r_hit;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_hit = 1'b0;
      while (!r_hit)
      begin
         @(negedge clk);
         ar_hit = arvalid && arready;
         r_hit = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_hit)
            arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask : rd
endmodule : qdl_host_model

// ---- test/qdl_core_tb.sv ----
/*
 Self-checking bench of the code-load core, 10-bit build, short
 calibration. Assumes the host model drives the register bus.
*/
`timescale 1ns/1ns
`include "qdl_map.svh"
module qdl_core_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic upd_n = 1'b1;
   logic zero_n = 1'b1;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, ref_sel;
   logic [47:0] codes;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;

   always #5 clk = ~clk;

   qdl_core #(.RES(10), .CAL_CYC(20)) dut_u (.SYS_CLK(clk), .SRST(srst),
      .HW_OUTPUT_UPDATE_N(upd_n), .ASYNC_ZERO_N(zero_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .ACTIVE_CODES(codes), .REF_SEL(ref_sel));

   qdl_host_model host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input string n, input logic [47:0] e,
      input logic [47:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic chk_resp(input string n, input logic [1:0] e,
      input logic [1:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_resp

   // A command's effect is registered on the edge that raises the response; two more cycles are waited.
   task automatic cmd(input qdl_pkg::qdl_op_t op, input logic [3:0] m,
      input logic [11:0] v);
      logic [1:0] r;
      host_u.wr(`QDL_OFS_CMD, {4'h0, op, 4'h0, m, 4'h0, v}, r);
      chk_resp("cmd resp", 2'h0, r);
      repeat (2) @(negedge clk);
   endtask : cmd

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      host_u.wr(a, d, r);
      chk_resp("reg resp", 2'h0, r);
      repeat (2) @(negedge clk);
   endtask : reg_wr

   task automatic rd_chk(input string n, input logic [7:0] a,
      input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      host_u.rd(a, d, r);
      chk(n, {16'h0, e}, {16'h0, d});
   endtask : rd_chk

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_cal();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      chk("reset codes", 48'h0, codes);
      chk("reset ref", 48'h0, {46'h0, ref_sel});
      cmd(qdl_pkg::QDL_OP_CODE_LOAD, 4'hF, 12'h3C0);
      chk("codes during cal", 48'h0, codes);
      d = 32'h0;
      for (n = 0; n < 100 && d[1] !== 1'b1; n++)
         host_u.rd(`QDL_OFS_STAT, d, r);
      chk("cal done", 48'h1, {47'h0, d[1]});
      rd_chk("ldcfg reset", `QDL_OFS_LDCFG, 32'hF);
   endtask : t_cal

   task automatic t_code();
      cmd(qdl_pkg::QDL_OP_CODE, 4'h3, 12'hABC);
      chk("pending only", 48'h0, codes);
      rd_chk("pending ch1", `QDL_OFS_CODE0 + 8'h04, 32'hABC);
      cmd(qdl_pkg::QDL_OP_LOAD, 4'h1, 12'h000);
      chk("load ch0", 48'h000_000_000_ABC, codes);
      cmd(qdl_pkg::QDL_OP_CODE_LOAD, 4'h8, 12'hFFF);
      chk("code load ch3", 48'hFFC_000_000_ABC, codes);
      rd_chk("active ch3", `QDL_OFS_ACT0 + 8'h0C, 32'hFFC);
   endtask : t_code

   task automatic t_ref();
      logic [1:0] i;
      for (int k = 0; k < 4; k++)
      begin
         i = k[1:0];
         reg_wr(`QDL_OFS_REF, {30'h0, i});
         chk("ref sel", {46'h0, i}, {46'h0, ref_sel});
      end
      cmd(qdl_pkg::QDL_OP_SOFT_RESTART, 4'h0, 12'h000);
      chk("restart codes", 48'h0, codes);
      chk("restart ref", 48'h0, {46'h0, ref_sel});
      cmd(qdl_pkg::QDL_OP_CODE_LOAD, 4'hF, 12'h124);
      cmd(qdl_pkg::QDL_OP_SOFT_ZERO, 4'h0, 12'h000);
      chk("soft zero", 48'h0, codes);
      rd_chk("soft zero pend", `QDL_OFS_CODE0 + 8'h08, 32'h0);
   endtask : t_ref

   task automatic t_pin();
      reg_wr(`QDL_OFS_LDCFG, 32'h5);
      cmd(qdl_pkg::QDL_OP_CODE, 4'hF, 12'h550);
      @(posedge clk);
      upd_n <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("pin load", 48'h000_550_000_550, codes);
      rd_chk("stat pin low", `QDL_OFS_STAT, 32'h3);
      cmd(qdl_pkg::QDL_OP_CODE, 4'h1, 12'h0AC);
      chk("transparent", 48'h000_550_000_0AC, codes);
      @(posedge clk);
      upd_n <= 1'b1;
      repeat (4) @(posedge clk);
      reg_wr(`QDL_OFS_LDCFG, 32'hF);
      chk("pin released", 48'h000_550_000_0AC, codes);
   endtask : t_pin

   task automatic t_clr();
      cmd(qdl_pkg::QDL_OP_CODE_LOAD, 4'hF, 12'h7F0);
      @(posedge clk);
      zero_n <= 1'b0;
      #2;
      chk("async clear", 48'h0, codes);
      cmd(qdl_pkg::QDL_OP_CODE_LOAD, 4'hF, 12'hFFF);
      chk("blocked write", 48'h0, codes);
      rd_chk("stat clear", `QDL_OFS_STAT, 32'h6);
      @(posedge clk);
      zero_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk("clear pend", `QDL_OFS_CODE0 + 8'h08, 32'h0);
   endtask : t_clr

   task automatic t_bad();
      logic [31:0] d;
      logic [1:0] r;
      host_u.rd(8'h40, d, r);
      chk_resp("bad read", 2'h2, r);
      chk("bad data", 48'h0, {16'h0, d});
      host_u.wr(8'h30, 32'h0, r);
      chk_resp("bad write", 2'h2, r);
   endtask : t_bad

   // -------------------------------------------------------------------
   // Sequence and timeout
   // -------------------------------------------------------------------
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_cal();
      t_code();
      t_ref();
      t_pin();
      t_clr();
      t_bad();
      wrap_up();
   end
endmodule : qdl_core_tb
